// ===== core/picc_cells.sv
/*
 Pin cell logic: turns configuration into registered driver and pull-up
 enables, and samples pad levels for read-back.
 Assumes pad inputs synchronous to core_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module picc_cells (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Configuration
    picc_cfg_if.cells cfg,
    // Pads
    input wire logic [16:0] pad_in,
    output logic [16:0] drive_high_en,
    output logic [16:0] drive_low_en,
    output logic [16:0] pullup_en,
    output logic [16:0] receiver_en
);
    typedef struct packed {
        logic [16:0] hi;
        logic [16:0] lo;
        logic [16:0] pu;
        logic [16:0] rx;
        logic [16:0] pad;
    } picc_cells_st_t;

    picc_cells_st_t st_ff;
    picc_cells_st_t nxt_st;

    always_comb begin
        logic dig;
        logic on;
        nxt_st = st_ff;
        dig = 1'b1;
        on = 1'b1;
        for (int i = 0; i < picc_pkg::NUM_PINS; i++) begin
            // Port 2 pin has no analog option
            dig = 1'b1;
            if (i < picc_pkg::NUM_MUX_PINS) begin
                dig = cfg.pin_analog_digital_select[i[3:0]];
            end
            on = dig && cfg.crossbar_enable_bit;
            nxt_st.hi[i] = on && cfg.pin_output_mode_select[i] && cfg.pin_output_latch[i];
            nxt_st.lo[i] = on && !cfg.pin_output_latch[i];
            // Pull-up only while not driving high or low, digital, and not disabled
            nxt_st.pu[i] = dig && !nxt_st.lo[i] && !nxt_st.hi[i] && !cfg.global_pullup_disable;
            nxt_st.rx[i] = dig;
            nxt_st.pad[i] = dig && pad_in[i];
        end
        if (reset) begin
            nxt_st.hi = '0;
            nxt_st.lo = '0;
            nxt_st.pu = {17{1'b1}};
            nxt_st.rx = {17{1'b1}};
            nxt_st.pad = '0;
        end
    end

    always_ff @(posedge core_clk) begin
        st_ff <= nxt_st;
    end

    assign drive_high_en = st_ff.hi;
    assign drive_low_en = st_ff.lo;
    assign pullup_en = st_ff.pu;
    assign receiver_en = st_ff.rx;
    assign cfg.pad_level = st_ff.pad;
endmodule // picc_cells
`default_nettype wire

// ===== core/picc_cfg_if.sv
/*
 Interface carrying the configuration word from the register file to the
 pin cell logic. Assumes one clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
interface picc_cfg_if;
    logic [16:0] pin_output_latch;
    logic [15:0] pin_analog_digital_select;
    logic [16:0] pin_output_mode_select;
    logic crossbar_enable_bit;
    logic global_pullup_disable;
    logic [16:0] pad_level;
    modport regs (output pin_output_latch, pin_analog_digital_select,
        pin_output_mode_select, crossbar_enable_bit, global_pullup_disable,
        input pad_level);
    modport cells (input pin_output_latch, pin_analog_digital_select,
        pin_output_mode_select, crossbar_enable_bit, global_pullup_disable,
        output pad_level);
endinterface
`default_nettype wire

// ===== core/picc_pkg.sv
/*
 Package for the port pin cell configuration block: register offsets,
 field positions, reset values and pin counts.
 Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
*/
package picc_pkg;
    localparam int NUM_PINS = 17;
    localparam int NUM_MUX_PINS = 16;
    localparam logic [3:0] ADDR_W = 4'h5;
    // Register byte offsets
    localparam logic [4:0] OFS_LATCH = 5'h00;
    localparam logic [4:0] OFS_ANADIG = 5'h04;
    localparam logic [4:0] OFS_OUTMODE = 5'h08;
    localparam logic [4:0] OFS_CTRL = 5'h0C;
    localparam logic [4:0] OFS_PAD = 5'h10;
    // Control register fields
    localparam int CTRL_XBAR_POS = 0;
    localparam int CTRL_PUD_POS = 1;
    // Reset values and bus response codes
    localparam logic [16:0] RST_LATCH = 17'h1FFFF;
    localparam logic [15:0] RST_ANADIG = 16'hFFFF;
    localparam logic [16:0] RST_OUTMODE = 17'h00000;
    localparam logic [1:0] RST_CTRL = 2'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {WR_IDLE, WR_RESP} picc_wr_t;
endpackage

// ===== core/picc_top.sv
/*
 Port pin cell configuration block with an AXI4-Lite register slave.
 Assumes a synchronous active-high reset and pad inputs synchronous to
 core_clk; the pad drivers are outside, steered by the enables here.
*/
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Reset gives high impedance with pull-ups on
// - Drivers off until crossbar enabled
// - Analog pin disables pull-up, driver, receiver
// - Analog pin reads back zero
// - Digital use needs select bit and mode
// - Push-pull drives pad to rail
// - Open-drain never drives high
// - Undriven digital pin gets weak pull-up
// - Pull-up off while driving low
// - Global disable turns all pull-ups off
// - Digital pin reads pad level
// - Port 2 pin is always digital
// - Ports 0 and 1 individually configurable
module picc_top (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // AXI4-Lite write address
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pads
    input wire logic [16:0] pad_in,
    output logic [16:0] drive_high_en,
    output logic [16:0] drive_low_en,
    output logic [16:0] pullup_en,
    output logic [16:0] receiver_en
);
    typedef struct packed {
        logic [16:0] latch;
        logic [15:0] anadig;
        logic [16:0] outmode;
        logic [1:0] ctrl;
        logic aw_got;
        logic [4:0] awaddr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic awready;
        logic wready;
        logic arready;
    } picc_top_st_t;

    picc_top_st_t st_ff;
    picc_top_st_t nxt_st;
    picc_cfg_if cfg ();

    // Byte-lane merge of a write into a 32-bit word
    function automatic logic [31:0] picc_merge(input logic [31:0] old,
        input logic [31:0] din, input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = din[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // Word-aligned form of a bus address
    function automatic logic [4:0] picc_align(input logic [4:0] a);
        return {a[4:2], 2'b00};
    endfunction

    function automatic logic picc_mapped(input logic [4:0] a);
        return a == picc_pkg::OFS_LATCH || a == picc_pkg::OFS_ANADIG ||
            a == picc_pkg::OFS_OUTMODE || a == picc_pkg::OFS_CTRL ||
            a == picc_pkg::OFS_PAD;
    endfunction

    always_comb begin
        logic [31:0] m;
        logic [4:0] ra;
        m = '0;
        ra = '0;
        nxt_st = st_ff;
        // Write channel capture, address and data in either order
        if (s_axi_awvalid && !st_ff.aw_got && !st_ff.bvalid) begin
            nxt_st.aw_got = 1'b1;
            nxt_st.awaddr = picc_align(s_axi_awaddr);
        end
        if (s_axi_wvalid && !st_ff.w_got && !st_ff.bvalid) begin
            nxt_st.w_got = 1'b1;
            nxt_st.wdata = s_axi_wdata;
            nxt_st.wstrb = s_axi_wstrb;
        end
        if (st_ff.aw_got && st_ff.w_got) begin
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = picc_mapped(st_ff.awaddr) ? picc_pkg::RESP_OKAY : picc_pkg::RESP_SLVERR;
            unique case (st_ff.awaddr)
                picc_pkg::OFS_LATCH: begin
                    m = picc_merge({15'h0000, st_ff.latch}, st_ff.wdata, st_ff.wstrb);
                    nxt_st.latch = m[16:0];
                end
                picc_pkg::OFS_ANADIG: begin
                    m = picc_merge({16'h0000, st_ff.anadig}, st_ff.wdata, st_ff.wstrb);
                    nxt_st.anadig = m[15:0];
                end
                picc_pkg::OFS_OUTMODE: begin
                    m = picc_merge({15'h0000, st_ff.outmode}, st_ff.wdata, st_ff.wstrb);
                    nxt_st.outmode = m[16:0];
                end
                picc_pkg::OFS_CTRL: begin
                    m = picc_merge({30'h00000000, st_ff.ctrl}, st_ff.wdata, st_ff.wstrb);
                    nxt_st.ctrl = m[1:0];
                end
                default: begin
                    m = '0;
                end
            endcase
        end
        if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
        end
        // Read channel: one read at a time
        if (s_axi_arvalid && !st_ff.rvalid) begin
            ra = picc_align(s_axi_araddr);
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp = picc_mapped(ra) ? picc_pkg::RESP_OKAY : picc_pkg::RESP_SLVERR;
            unique case (ra)
                picc_pkg::OFS_LATCH: nxt_st.rdata = {15'h0000, st_ff.latch};
                picc_pkg::OFS_ANADIG: nxt_st.rdata = {16'h0000, st_ff.anadig};
                picc_pkg::OFS_OUTMODE: nxt_st.rdata = {15'h0000, st_ff.outmode};
                picc_pkg::OFS_CTRL: nxt_st.rdata = {30'h00000000, st_ff.ctrl};
                picc_pkg::OFS_PAD: nxt_st.rdata = {15'h0000, cfg.pad_level};
                default: nxt_st.rdata = '0;
            endcase
        end else if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
        end
        if (reset) begin
            nxt_st = '0;
            nxt_st.latch = picc_pkg::RST_LATCH;
            nxt_st.anadig = picc_pkg::RST_ANADIG;
            nxt_st.outmode = picc_pkg::RST_OUTMODE;
            nxt_st.ctrl = picc_pkg::RST_CTRL;
        end
        // Ready flags kept in flops so every bus output comes from a register
        nxt_st.awready = !nxt_st.aw_got && !nxt_st.bvalid;
        nxt_st.wready = !nxt_st.w_got && !nxt_st.bvalid;
        nxt_st.arready = !nxt_st.rvalid;
    end

    always_ff @(posedge core_clk) begin
        st_ff <= nxt_st;
    end

    assign cfg.pin_output_latch = st_ff.latch;
    assign cfg.pin_analog_digital_select = st_ff.anadig;
    assign cfg.pin_output_mode_select = st_ff.outmode;
    assign cfg.crossbar_enable_bit = st_ff.ctrl[picc_pkg::CTRL_XBAR_POS];
    assign cfg.global_pullup_disable = st_ff.ctrl[picc_pkg::CTRL_PUD_POS];

    assign s_axi_awready = st_ff.awready;
    assign s_axi_wready = st_ff.wready;
    assign s_axi_bvalid = st_ff.bvalid;
    assign s_axi_bresp = st_ff.bresp;
    assign s_axi_arready = st_ff.arready;
    assign s_axi_rvalid = st_ff.rvalid;
    assign s_axi_rdata = st_ff.rdata;
    assign s_axi_rresp = st_ff.rresp;

    picc_cells u_cells (
        .core_clk(core_clk),
        .reset(reset),
        .cfg(cfg.cells),
        .pad_in(pad_in),
        .drive_high_en(drive_high_en),
        .drive_low_en(drive_low_en),
        .pullup_en(pullup_en),
        .receiver_en(receiver_en)
    );
endmodule // picc_top
`default_nettype wire

// ===== testbench/picc_assertions.sv
/*
 Checker for the pin cell block: watches top-level ports only.
 Assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none
module picc_assertions (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Register bus
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_bvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    // Pads
    input wire logic [16:0] drive_high_en,
    input wire logic [16:0] drive_low_en,
    input wire logic [16:0] pullup_en,
    input wire logic [16:0] receiver_en
);
    logic rd_pad_ff;
    // Remembers whether the read under way targets the pad register
    always_ff @(posedge core_clk) begin
        if (s_axi_arvalid && s_axi_arready) begin
            rd_pad_ff <= (s_axi_araddr == picc_pkg::OFS_PAD);
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    AST_RST_STATE: assert property ($fell(reset) |-> pullup_en == 17'h1FFFF && receiver_en == 17'h1FFFF)
        else $error("Pins not in reset state");
    AST_XBAR_OFF: assert property ($fell(reset) |-> ((drive_high_en | drive_low_en) == 17'h00000) [*3])
        else $error("Driver on before crossbar enabled");
    AST_ANALOG_OFF: assert property (((pullup_en | drive_high_en | drive_low_en) & ~receiver_en) == 17'h00000)
        else $error("Analog pin has pull-up or driver on");
    AST_ANALOG_READ0: assert property (s_axi_rvalid && rd_pad_ff |-> (s_axi_rdata[16:0] & ~receiver_en) == 17'h00000)
        else $error("Analog pin read nonzero");
    AST_NO_SHOOT: assert property ((drive_high_en & drive_low_en) == 17'h00000)
        else $error("Both drivers on");
    AST_PULL_LOW: assert property ((pullup_en & drive_low_en) == 17'h00000)
        else $error("Pull-up on while driving low");
    AST_PORT2_DIG: assert property (receiver_en[16] == 1'b1)
        else $error("Port 2 pin not digital");
    AST_DRV_AFTER_WR: assert property ($changed(drive_high_en) || $changed(drive_low_en) |-> $past(s_axi_bvalid))
        else $error("Drivers changed without a write");
endmodule // picc_assertions
`default_nettype wire

// ===== testbench/picc_pad_model.sv
/*
 External circuitry on the pads: resolves device drivers, an outside source
 and the weak pull-up; undriven pads wander. Assumes one clock.
*/
`timescale 1ns/10ps
`default_nettype none
module picc_pad_model (
    // Clock
    input wire logic core_clk,
    // Device side
    input wire logic [16:0] drive_high_en,
    input wire logic [16:0] drive_low_en,
    input wire logic [16:0] pullup_en,
    // Outside source
    input wire logic [16:0] ext_drive,
    input wire logic [16:0] ext_level,
    // Pad levels
    output logic [16:0] pad_in
);
    logic [16:0] float_ff = 17'h00000;
    always @(posedge core_clk) float_ff <= ~float_ff;
    always_comb begin
        for (int i = 0; i < 17; i++) begin
            if (drive_low_en[i]) pad_in[i] = 1'b0;
            else if (drive_high_en[i]) pad_in[i] = 1'b1;
            else if (ext_drive[i]) pad_in[i] = ext_level[i];
            else if (pullup_en[i]) pad_in[i] = 1'b1;
            else pad_in[i] = float_ff[i];
        end
    end
endmodule // picc_pad_model
`default_nettype wire

// ===== testbench/picc_top_test.sv
/*
 Testbench for the pin cell block: AXI4-Lite tasks, pad model, checks.
 Assumes the checker and pad model are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module picc_top_test;
    logic core_clk = 1'b0, reset = 1'b1;
    logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [16:0] pad_in, drive_high_en, drive_low_en, pullup_en, receiver_en;
    logic [16:0] ext_drive = 17'h00000, ext_level = 17'h0A5C3;
    logic [31:0] d;
    int n_fail = 0, n_compared = 0, cycles = 0;
    picc_top picc_top_inst (.core_clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pad_in, .drive_high_en, .drive_low_en,
        .pullup_en, .receiver_en);
    picc_pad_model picc_pad_model_inst (.core_clk, .drive_high_en, .drive_low_en, .pullup_en,
        .ext_drive, .ext_level, .pad_in);
    initial begin
        forever #10 core_clk = ~core_clk;
    end
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            give_verdict();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic axi_wr(input logic [4:0] a, input logic [31:0] v,
        input logic [1:0] er = picc_pkg::RESP_OKAY, input logic [3:0] st = 4'hF);
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk("bresp", 32'(s_axi_bresp), 32'(er));
    endtask
    task automatic axi_rd(input logic [4:0] a);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic cfg(input logic [16:0] l, m, input logic [15:0] a, input logic [1:0] c);
        logic [16:0] dig, hi, lo, pu;
        dig = {1'b1, a};
        hi = c[0] ? (l & m & dig) : 17'h00000;
        lo = c[0] ? (~l & dig) : 17'h00000;
        pu = c[1] ? 17'h00000 : (dig & ~hi & ~lo);
        ext_drive <= ~(hi | lo);
        axi_wr(picc_pkg::OFS_LATCH, 32'(l));
        axi_wr(picc_pkg::OFS_ANADIG, 32'(a));
        axi_wr(picc_pkg::OFS_OUTMODE, 32'(m));
        axi_wr(picc_pkg::OFS_CTRL, 32'(c));
        repeat (2) @(posedge core_clk);
        chk("drive_high_en", 32'(drive_high_en), 32'(hi));
        chk("drive_low_en", 32'(drive_low_en), 32'(lo));
        chk("pullup_en", 32'(pullup_en), 32'(pu));
        chk("receiver_en", 32'(receiver_en), 32'(dig));
        axi_rd(picc_pkg::OFS_PAD);
        chk("pad_read", d, 32'((hi | (~lo & ext_level)) & dig));
    endtask
    initial begin
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        chk("pullup_rst", 32'(pullup_en), 32'h0001FFFF);
        chk("drive_rst", 32'(drive_high_en | drive_low_en), 32'h00000000);
        axi_rd(picc_pkg::OFS_LATCH);
        chk("latch_rst", d, 32'(picc_pkg::RST_LATCH));
        axi_rd(5'h14);
        chk("unmapped_resp", 32'(r), 32'(picc_pkg::RESP_SLVERR));
        chk("unmapped_data", d, 32'h00000000);
        axi_wr(5'h14, 32'h0001FFFF, picc_pkg::RESP_SLVERR);
        axi_wr(picc_pkg::OFS_LATCH, 32'h00000000, picc_pkg::RESP_OKAY, 4'h2);
        axi_rd(picc_pkg::OFS_LATCH);
        chk("latch_strobe", d, 32'h000100FF);
        cfg(17'h00000, 17'h1FFFF, 16'hFFFF, 2'h0);
        cfg(17'h00000, 17'h00000, 16'hFFFF, 2'h1);
        cfg(17'h0F0F0, 17'h1CC33, 16'hFFFF, 2'h1);
        cfg(17'h100FF, 17'h0F0F0, 16'hFF00, 2'h1);
        cfg(17'h0F0F0, 17'h00000, 16'hFFFF, 2'h3);
        cfg(17'h0FFFF, 17'h10000, 16'h0000, 2'h1);
        @(posedge core_clk);
        reset <= 1'b1;
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        chk("pullup_rst2", 32'(pullup_en), 32'h0001FFFF);
        chk("drive_rst2", 32'(drive_high_en | drive_low_en), 32'h00000000);
        give_verdict();
    end
endmodule // picc_top_test
bind picc_top picc_assertions picc_assertions_inst (.core_clk, .reset, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_bvalid, .s_axi_rdata, .s_axi_rvalid,
    .drive_high_en, .drive_low_en, .pullup_en, .receiver_en);
`default_nettype wire
